// *** logic/gpm_pkg.sv ***
// Purpose: constants and types for the three-port gpio block with misc control
// Assumes: axi4-lite register access, 32-bit data, 8-bit registers in low bits
// Notes: printed offsets are not all multiples of four, so they are indices
//
// Overview of operation
// - data writes always update the output latch
// - data read: latch if output, pin if input
// - direction bit 0 input, 1 output
// - input option: 0 floating, 1 pull-up
// - output option: 0 open-drain, 1 push-pull
// - pins without option act as open-drain outputs and floating inputs
// - all registers reset to zero
// - group b sense field encoding, four ways
// - group a sense field, same encoding
// - sense writes only while interrupts masked
// - clock enable bit drives core clock to pin
// - slow divider: 4, 8, 16, 32 selection
// - slow select 0 divides by two
// - upper four bits of second reg read zero
// - master tx disable suppresses mosi drive
// - slave tx disable suppresses miso drive
// - select source: pin or soft level
// - select pin stays gpio for either select source
// - group pin levels anded before detection
// - request cleared on vector fetch or sense change
package gpm_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PORT_C_DATA = 8'h00;
  localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h01;
  localparam logic [7:0] IDX_PORT_C_DRIVE_OPTION = 8'h02;
  localparam logic [7:0] IDX_PORT_B_DATA = 8'h04;
  localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h05;
  localparam logic [7:0] IDX_PORT_B_DRIVE_OPTION = 8'h06;
  localparam logic [7:0] IDX_PORT_A_DATA = 8'h08;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h09;
  localparam logic [7:0] IDX_PORT_A_DRIVE_OPTION = 8'h0A;
  localparam logic [7:0] IDX_MISC_ONE = 8'h20;
  localparam logic [7:0] IDX_MISC_TWO = 8'h40;
  localparam logic [7:0] REG_RESET = 8'h00;
  // misc_control_one fields
  localparam int B_SENSE_HI = 7;
  localparam int B_SENSE_LO = 6;
  localparam int CLK_PIN_BIT = 5;
  localparam int A_SENSE_HI = 4;
  localparam int A_SENSE_LO = 3;
  localparam int DIV_HI = 2;
  localparam int DIV_LO = 1;
  localparam int SLOW_BIT = 0;
  // misc_control_two fields
  localparam int MTX_DIS_BIT = 3;
  localparam int STX_DIS_BIT = 2;
  localparam int SEL_SRC_BIT = 1;
  localparam int SOFT_SEL_BIT = 0;
  localparam logic [7:0] MISC_TWO_MASK = 8'h0F;
  // pin index of the clock output on port c, select pin on port b
  localparam int CLK_OUT_PIN = 2;
  localparam int SELECT_PIN = 7;
  localparam int MOSI_PIN = 4;
  localparam int MISO_PIN = 5;
  // option-register implementation masks, 1 = option bit exists
  localparam logic [7:0] PORT_A_OPT_MASK = 8'hAF;
  localparam logic [7:0] PORT_B_OPT_MASK = 8'hFF;
  localparam logic [7:0] PORT_C_OPT_MASK = 8'hFF;
  // divider codes: core clock = oscillator / ratio
  localparam logic [5:0] DIV_NORMAL = 6'h02;
  localparam logic [5:0] DIV_CODE00 = 6'h04;
  localparam logic [5:0] DIV_CODE10 = 6'h08;
  localparam logic [5:0] DIV_CODE01 = 6'h10;
  localparam logic [5:0] DIV_CODE11 = 6'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SENSE_FALL_LOW,
    SENSE_RISE,
    SENSE_FALL,
    SENSE_BOTH
  } gpm_sense_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] opt;
  } gpm_port_t;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pull_en;
  } gpm_pad_t;
endpackage

// *** logic/gpm_top.sv ***
// Purpose: three 8-bit gpio ports plus misc interrupt, clock and spi pin control
// Assumes: pins synchronous to aclk; spi, irq controller and clock gen are outside
// Notes: 8-bit registers answer in the low byte of a 32-bit axi4-lite word
`timescale 1ns/1ps
module gpm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_masked,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  output gpm_pkg::gpm_pad_t port_a_pad,
  output gpm_pkg::gpm_pad_t port_b_pad,
  output gpm_pkg::gpm_pad_t port_c_pad,
  input wire logic core_clock,
  input wire logic spi_active,
  input wire logic spi_mosi_out,
  input wire logic spi_mosi_oe,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe,
  output logic spi_select_in,
  input wire logic [7:0] group_a_enable,
  input wire logic [7:0] group_b_enable,
  input wire logic vector_fetch_a,
  input wire logic vector_fetch_b,
  output logic ext_irq_group_a,
  output logic ext_irq_group_b,
  output logic [5:0] clock_divide_ratio
);

  // ==========================================================================
  // bus handshake
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] aw_idx_ff;
  logic [7:0] w_data_ff;
  logic w_lane_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [7:0] rdata_ff;
  logic rerr_ff;
  logic berr_ff;

  wire aw_take = s_axi_awvalid && !aw_hold_ff && !bvalid_ff;
  wire w_take = s_axi_wvalid && !w_hold_ff && !bvalid_ff;
  wire have_aw = aw_hold_ff || aw_take;
  wire have_w = w_hold_ff || w_take;
  wire wr_fire = have_aw && have_w && !bvalid_ff;
  wire [7:0] wr_idx = aw_hold_ff ? aw_idx_ff : s_axi_awaddr[9:2];
  wire [7:0] wr_byte = w_hold_ff ? w_data_ff : s_axi_wdata[7:0];
  wire wr_lane = w_hold_ff ? w_lane_ff : s_axi_wstrb[0];
  wire ar_take = s_axi_arvalid && !rvalid_ff;
  wire [7:0] rd_idx = s_axi_araddr[9:2];

  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_bresp = berr_ff ? gpm_pkg::RESP_SLVERR : gpm_pkg::RESP_OKAY;
  assign s_axi_rresp = rerr_ff ? gpm_pkg::RESP_SLVERR : gpm_pkg::RESP_OKAY;
  assign s_axi_rdata = {24'h000000, rdata_ff};

  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == gpm_pkg::IDX_PORT_C_DATA) || (idx == gpm_pkg::IDX_PORT_C_DIRECTION) ||
                 (idx == gpm_pkg::IDX_PORT_C_DRIVE_OPTION) || (idx == gpm_pkg::IDX_PORT_B_DATA) ||
                 (idx == gpm_pkg::IDX_PORT_B_DIRECTION) ||
                 (idx == gpm_pkg::IDX_PORT_B_DRIVE_OPTION) || (idx == gpm_pkg::IDX_PORT_A_DATA) ||
                 (idx == gpm_pkg::IDX_PORT_A_DIRECTION) ||
                 (idx == gpm_pkg::IDX_PORT_A_DRIVE_OPTION) || (idx == gpm_pkg::IDX_MISC_ONE) ||
                 (idx == gpm_pkg::IDX_MISC_TWO);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      berr_ff <= 1'b0;
    end else begin
      aw_hold_ff <= have_aw && !wr_fire;
      w_hold_ff <= have_w && !wr_fire;
      if (aw_take) begin
        aw_idx_ff <= s_axi_awaddr[9:2];
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        berr_ff <= !idx_mapped(wr_idx);
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // registers
  gpm_pkg::gpm_port_t port_a_ff;
  gpm_pkg::gpm_port_t port_b_ff;
  gpm_pkg::gpm_port_t port_c_ff;
  logic [7:0] misc_one_ff;
  logic [3:0] misc_two_ff;

  function automatic logic hit(input logic [7:0] idx);
    hit = wr_fire && wr_lane && (wr_idx == idx);
  endfunction

  // sense fields are locked unless the core masks interrupts
  wire [7:0] sense_keep = irq_masked ? 8'h00 : 8'hD8;
  wire [7:0] nxt_misc_one = (wr_byte & ~sense_keep) | (misc_one_ff & sense_keep);
  wire misc_one_wr = hit(gpm_pkg::IDX_MISC_ONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_ff <= '0;
      port_b_ff <= '0;
      port_c_ff <= '0;
      misc_one_ff <= gpm_pkg::REG_RESET;
      misc_two_ff <= 4'h0;
    end else begin
      // latch written regardless of direction
      if (hit(gpm_pkg::IDX_PORT_A_DATA)) port_a_ff.data <= wr_byte;
      if (hit(gpm_pkg::IDX_PORT_B_DATA)) port_b_ff.data <= wr_byte;
      if (hit(gpm_pkg::IDX_PORT_C_DATA)) port_c_ff.data <= wr_byte;
      if (hit(gpm_pkg::IDX_PORT_A_DIRECTION)) port_a_ff.dir <= wr_byte;
      if (hit(gpm_pkg::IDX_PORT_B_DIRECTION)) port_b_ff.dir <= wr_byte;
      if (hit(gpm_pkg::IDX_PORT_C_DIRECTION)) port_c_ff.dir <= wr_byte;
      if (hit(gpm_pkg::IDX_PORT_A_DRIVE_OPTION)) begin
        port_a_ff.opt <= wr_byte & gpm_pkg::PORT_A_OPT_MASK;
      end
      if (hit(gpm_pkg::IDX_PORT_B_DRIVE_OPTION)) begin
        port_b_ff.opt <= wr_byte & gpm_pkg::PORT_B_OPT_MASK;
      end
      if (hit(gpm_pkg::IDX_PORT_C_DRIVE_OPTION)) begin
        port_c_ff.opt <= wr_byte & gpm_pkg::PORT_C_OPT_MASK;
      end
      if (misc_one_wr) misc_one_ff <= nxt_misc_one;
      if (hit(gpm_pkg::IDX_MISC_TWO)) misc_two_ff <= wr_byte[3:0];
    end
  end

  // ==========================================================================
  // pads
  gpm_pkg::gpm_pad_t nxt_pad [3];
  gpm_pkg::gpm_port_t ports [3];
  wire [7:0] pins_in [3];
  assign ports[0] = port_a_ff;
  assign ports[1] = port_b_ff;
  assign ports[2] = port_c_ff;
  assign pins_in[0] = port_a_in;
  assign pins_in[1] = port_b_in;
  assign pins_in[2] = port_c_in;

  wire [7:0] rd_port [3];
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_port
      // output high drives only in push-pull, open-drain releases the line
      assign nxt_pad[gp].pin_out = ports[gp].data;
      assign nxt_pad[gp].pin_oe = ports[gp].dir & (~ports[gp].data | ports[gp].opt);
      assign nxt_pad[gp].pull_en = ~ports[gp].dir & ports[gp].opt;
      assign rd_port[gp] = (ports[gp].dir & ports[gp].data) | (~ports[gp].dir & pins_in[gp]);
    end
  endgenerate

  // alternate functions override plain gpio
  wire clk_pin_on = misc_one_ff[gpm_pkg::CLK_PIN_BIT];
  wire sel_override = misc_two_ff[gpm_pkg::SEL_SRC_BIT];
  wire mosi_on = spi_active && spi_mosi_oe && !misc_two_ff[gpm_pkg::MTX_DIS_BIT];
  wire miso_on = spi_active && spi_miso_oe && !misc_two_ff[gpm_pkg::STX_DIS_BIT];
  gpm_pkg::gpm_pad_t pad_b_alt;
  gpm_pkg::gpm_pad_t pad_c_alt;

  always_comb begin
    pad_b_alt = nxt_pad[1];
    if (mosi_on) begin
      pad_b_alt.pin_out[gpm_pkg::MOSI_PIN] = spi_mosi_out;
      pad_b_alt.pin_oe[gpm_pkg::MOSI_PIN] = 1'b1;
    end
    if (miso_on) begin
      pad_b_alt.pin_out[gpm_pkg::MISO_PIN] = spi_miso_out;
      pad_b_alt.pin_oe[gpm_pkg::MISO_PIN] = 1'b1;
    end
    pad_c_alt = nxt_pad[2];
    if (clk_pin_on) begin
      pad_c_alt.pin_out[gpm_pkg::CLK_OUT_PIN] = core_clock;
      pad_c_alt.pin_oe[gpm_pkg::CLK_OUT_PIN] = 1'b1;
    end
  end

  // clock pin passes combinationally so the core clock is not resampled
  assign port_c_pad = pad_c_alt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_pad <= '0;
      port_b_pad <= '0;
    end else begin
      port_a_pad <= nxt_pad[0];
      port_b_pad <= pad_b_alt;
    end
  end

  // select pin stays ordinary gpio; spi sees pin or soft level
  assign spi_select_in = sel_override ? misc_two_ff[gpm_pkg::SOFT_SEL_BIT]
                                      : port_b_in[gpm_pkg::SELECT_PIN];

  // ==========================================================================
  // clock divider select
  wire [1:0] div_code = misc_one_ff[gpm_pkg::DIV_HI:gpm_pkg::DIV_LO];
  wire [5:0] slow_ratio = (div_code == 2'b00) ? gpm_pkg::DIV_CODE00 :
                          (div_code == 2'b10) ? gpm_pkg::DIV_CODE10 :
                          (div_code == 2'b01) ? gpm_pkg::DIV_CODE01 :
                          gpm_pkg::DIV_CODE11;
  assign clock_divide_ratio = misc_one_ff[gpm_pkg::SLOW_BIT] ? slow_ratio
                                                               : gpm_pkg::DIV_NORMAL;

  // ==========================================================================
  // external interrupt detection
  wire [7:0] grp_a_lvl = port_a_in | ~group_a_enable;
  wire [7:0] grp_b_lvl = port_b_in | ~group_b_enable;
  wire line_a = &grp_a_lvl;
  wire line_b = &grp_b_lvl;
  logic line_a_ff;
  logic line_b_ff;
  logic req_a_ff;
  logic req_b_ff;

  function automatic logic sense_hit(input logic [1:0] s, input logic now, input logic was);
    case (gpm_pkg::gpm_sense_t'(s))
      gpm_pkg::SENSE_FALL_LOW: sense_hit = !now;
      gpm_pkg::SENSE_RISE: sense_hit = now && !was;
      gpm_pkg::SENSE_FALL: sense_hit = !now && was;
      gpm_pkg::SENSE_BOTH: sense_hit = now != was;
      default: sense_hit = 1'b0;
    endcase
  endfunction

  wire [1:0] sense_a = misc_one_ff[gpm_pkg::A_SENSE_HI:gpm_pkg::A_SENSE_LO];
  wire [1:0] sense_b = misc_one_ff[gpm_pkg::B_SENSE_HI:gpm_pkg::B_SENSE_LO];
  wire ev_a = (group_a_enable != 8'h00) && sense_hit(sense_a, line_a, line_a_ff);
  wire ev_b = (group_b_enable != 8'h00) && sense_hit(sense_b, line_b, line_b_ff);
  wire chg_a = misc_one_wr && (nxt_misc_one[4:3] != sense_a);
  wire chg_b = misc_one_wr && (nxt_misc_one[7:6] != sense_b);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_a_ff <= 1'b1;
      line_b_ff <= 1'b1;
      req_a_ff <= 1'b0;
      req_b_ff <= 1'b0;
    end else begin
      line_a_ff <= line_a;
      line_b_ff <= line_b;
      // a new event wins over a clear in the same cycle
      req_a_ff <= ev_a || (req_a_ff && !vector_fetch_a && !chg_a);
      req_b_ff <= ev_b || (req_b_ff && !vector_fetch_b && !chg_b);
    end
  end

  assign ext_irq_group_a = req_a_ff;
  assign ext_irq_group_b = req_b_ff;

  // ==========================================================================
  // read path
  wire [7:0] rd_mux = (rd_idx == gpm_pkg::IDX_PORT_A_DATA) ? rd_port[0] :
                      (rd_idx == gpm_pkg::IDX_PORT_B_DATA) ? rd_port[1] :
                      (rd_idx == gpm_pkg::IDX_PORT_C_DATA) ? rd_port[2] :
                      (rd_idx == gpm_pkg::IDX_PORT_A_DIRECTION) ? port_a_ff.dir :
                      (rd_idx == gpm_pkg::IDX_PORT_B_DIRECTION) ? port_b_ff.dir :
                      (rd_idx == gpm_pkg::IDX_PORT_C_DIRECTION) ? port_c_ff.dir :
                      (rd_idx == gpm_pkg::IDX_PORT_A_DRIVE_OPTION) ? port_a_ff.opt :
                      (rd_idx == gpm_pkg::IDX_PORT_B_DRIVE_OPTION) ? port_b_ff.opt :
                      (rd_idx == gpm_pkg::IDX_PORT_C_DRIVE_OPTION) ? port_c_ff.opt :
                      (rd_idx == gpm_pkg::IDX_MISC_ONE) ? misc_one_ff :
                      (rd_idx == gpm_pkg::IDX_MISC_TWO) ? {4'h0, misc_two_ff} :
                      8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rerr_ff <= 1'b0;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rerr_ff <= !idx_mapped(rd_idx);
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// *** tb/gpm_top_sva.sv ***
// Purpose: port-level assertions for gpm_top
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to every gpm_top by the bind below
`timescale 1ns/1ps
module gpm_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_group_a,
  input wire logic ext_irq_group_b,
  input wire logic [5:0] clock_divide_ratio,
  input wire gpm_pkg::gpm_pad_t port_a_pad
);
  // ==========
  // bus and pad relations
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ratio_legal: assert property (
    clock_divide_ratio inside {6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("illegal divide ratio");
  a_pull_input: assert property (
    (port_a_pad.pull_en & port_a_pad.pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_true_drain: assert property (
    !port_a_pad.pull_en[6] && !port_a_pad.pull_en[4] &&
    !(port_a_pad.pin_oe[6] && port_a_pad.pin_out[6]) &&
    !(port_a_pad.pin_oe[4] && port_a_pad.pin_out[4]))
    else $error("drain-only pin driven high or pulled");
  a_reset_clean: assert property (
    $rose(aresetn) |-> clock_divide_ratio == 6'h02 && !ext_irq_group_a &&
    !ext_irq_group_b && port_a_pad == 24'h000000)
    else $error("state not cleared by reset");
endmodule

bind gpm_top gpm_top_sva u_gpm_top_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_irq_group_a(ext_irq_group_a), .ext_irq_group_b(ext_irq_group_b),
  .clock_divide_ratio(clock_divide_ratio), .port_a_pad(port_a_pad)
);

// *** tb/gpm_board.sv ***
// Purpose: board circuitry on one 8-bit port
// Assumes: bench drive loses to the device's own drive
// Notes: undriven, unpulled bits wander so no stale level is read
`timescale 1ns/1ps
module gpm_board (
  input wire logic aclk,
  input wire gpm_pkg::gpm_pad_t pad,
  input wire logic [7:0] drv_val,
  input wire logic [7:0] drv_en,
  output logic [7:0] level
);
  logic wobble_ff = 1'b0;
  always_ff @(posedge aclk) begin
    wobble_ff <= !wobble_ff;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.pin_oe[i]) level[i] = pad.pin_out[i];
      else if (drv_en[i]) level[i] = drv_val[i];
      else if (pad.pull_en[i]) level[i] = 1'b1;
      else level[i] = wobble_ff ^ i[0];
    end
  end
endmodule

// *** tb/gpm_top_test.sv ***
// Purpose: self-checking bench for gpm_top
// Assumes: one gpm_board per port resolves the pin levels
// Notes: registers reached as an axi4-lite master
`timescale 1ns/1ps
module gpm_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_a, irq_b, sel_in;
  logic [1:0] bresp, rresp, bres, rrq;
  logic [5:0] ratio;
  logic irq_masked = 1'b1, core_clock = 1'b0, spi_active = 1'b0;
  logic [3:0] spi_drv = 4'h0;
  logic [1:0] fetch = 2'h0;
  logic [7:0] en [2] = '{8'h00, 8'h00};
  logic [7:0] dv [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] de [3] = '{8'hFF, 8'hFF, 8'hFF};
  logic [7:0] pin [3];
  gpm_pkg::gpm_pad_t pad [3];
  int num_errors = 0;
  int num_checks = 0;

  always #5 aclk = ~aclk;

  gpm_top u_gpm_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_masked(irq_masked), .port_a_in(pin[0]), .port_b_in(pin[1]), .port_c_in(pin[2]),
    .port_a_pad(pad[0]), .port_b_pad(pad[1]), .port_c_pad(pad[2]),
    .core_clock(core_clock), .spi_active(spi_active), .spi_mosi_out(spi_drv[3]),
    .spi_mosi_oe(spi_drv[2]), .spi_miso_out(spi_drv[1]), .spi_miso_oe(spi_drv[0]),
    .spi_select_in(sel_in), .group_a_enable(en[0]), .group_b_enable(en[1]),
    .vector_fetch_a(fetch[0]), .vector_fetch_b(fetch[1]), .ext_irq_group_a(irq_a),
    .ext_irq_group_b(irq_b), .clock_divide_ratio(ratio)
  );
  for (genvar p = 0; p < 3; p++) begin : g_board
    gpm_board u_board (.aclk(aclk), .pad(pad[p]), .drv_val(dv[p]), .drv_en(de[p]),
      .level(pin[p]));
  end

  // ==========
  // helpers
  function automatic logic [7:0] base_of(input int p);
    return p == 0 ? gpm_pkg::IDX_PORT_A_DATA :
      p == 1 ? gpm_pkg::IDX_PORT_B_DATA : gpm_pkg::IDX_PORT_C_DATA;
  endfunction
  function automatic logic [7:0] mask_of(input int p);
    return p == 0 ? gpm_pkg::PORT_A_OPT_MASK :
      p == 1 ? gpm_pkg::PORT_B_OPT_MASK : gpm_pkg::PORT_C_OPT_MASK;
  endfunction
  // open drain drives only the low level
  function automatic logic [7:0] exp_oe(input logic [7:0] d, dir_v, op, mk);
    return dir_v & ((op & mk) | ~d);
  endfunction
  function automatic logic [7:0] exp_ratio(input logic [7:0] v);
    return !v[0] ? 8'h02 : v[2:1] == 2'h0 ? 8'h04 : v[2:1] == 2'h1 ? 8'h10 :
      v[2:1] == 2'h2 ? 8'h08 : 8'h20;
  endfunction
  function automatic logic [7:0] irq_of(input int g);
    return {7'h00, g != 0 ? irq_b : irq_a};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ready stays high between transfers; only the watchdog ends a hung wait
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bres = bresp;
  endtask
  task automatic rd(input logic [7:0] idx);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdq = rdata;
    rrq = rresp;
  endtask
  task automatic chk_rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    check(what, rdq[7:0], exp);
  endtask
  task automatic pulse(input int g);
    fetch <= g != 0 ? 2'h2 : 2'h1;
    @(posedge aclk);
    fetch <= 2'h0;
    @(posedge aclk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    results();
  end

  // ==========
  // main sequence
  initial begin
    logic [7:0] d, dir_v, op, v;
    void'($urandom(32'hDF1BB72E));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) chk_rd("port reset", base_of(p) + 8'(k), 8'h00);
    end
    chk_rd("misc one reset", gpm_pkg::IDX_MISC_ONE, 8'h00);
    chk_rd("misc two reset", gpm_pkg::IDX_MISC_TWO, 8'h00);
    rd(8'h03);
    check("unmapped read", {6'h0, rrq}, {6'h0, gpm_pkg::RESP_SLVERR});
    wr(8'h03, 8'hFF);
    check("unmapped write", {6'h0, bres}, {6'h0, gpm_pkg::RESP_SLVERR});
    $display("test reset done");
    repeat (8) begin
      for (int p = 0; p < 3; p++) begin
        d = 8'($urandom);
        dir_v = 8'($urandom);
        op = 8'($urandom);
        dv[p] <= 8'($urandom);
        en[p % 2] <= 8'($urandom);
        wr(base_of(p), d);
        wr(base_of(p) + 8'h01, dir_v);
        wr(base_of(p) + 8'h02, op);
        repeat (2) @(posedge aclk);
        v = exp_oe(d, dir_v, op, mask_of(p));
        check("pin enable", pad[p].pin_oe, v);
        check("pull enable", pad[p].pull_en, ~dir_v & op & mask_of(p));
        check("pin level", pad[p].pin_out & v, d & v);
        chk_rd("port data", base_of(p), (d & dir_v) | (dv[p] & ~dir_v));
        chk_rd("port option", base_of(p) + 8'h02, op & mask_of(p));
        chk_rd("port direction", base_of(p) + 8'h01, dir_v);
      end
    end
    $display("test ports done");
    irq_masked <= 1'b0;
    wr(gpm_pkg::IDX_MISC_ONE, 8'hD8);
    chk_rd("sense refused", gpm_pkg::IDX_MISC_ONE, 8'h00);
    irq_masked <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      v = (8'($urandom) & 8'hD8) | {2'h0, i[3], 2'h0, i[2:0]};
      core_clock <= 1'($urandom);
      wr(gpm_pkg::IDX_MISC_ONE, v);
      check("divide ratio", {2'h0, ratio}, exp_ratio(v));
      if (v[5]) check("clock pin", {6'h0, pad[2].pin_oe[2], pad[2].pin_out[2]},
        {6'h0, 1'b1, core_clock});
      chk_rd("misc one", gpm_pkg::IDX_MISC_ONE, v);
    end
    $display("test misc one done");
    wr(gpm_pkg::IDX_PORT_B_DATA, 8'h80);
    wr(gpm_pkg::IDX_PORT_B_DIRECTION, 8'h80);
    wr(gpm_pkg::IDX_PORT_B_DRIVE_OPTION, 8'h80);
    de[1] <= 8'h7F;
    spi_active <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      spi_drv <= {1'($urandom), 1'b1, 1'($urandom), 1'b1};
      dv[1] <= 8'($urandom);
      wr(gpm_pkg::IDX_MISC_TWO, {4'($urandom), 4'(i)});
      repeat (2) @(posedge aclk);
      chk_rd("misc two", gpm_pkg::IDX_MISC_TWO, 8'(i));
      check("mosi drive", {7'h0, pad[1].pin_oe[4]}, {7'h0, !i[3]});
      if (!i[3]) check("mosi level", {7'h0, pad[1].pin_out[4]}, {7'h0, spi_drv[3]});
      check("miso drive", {7'h0, pad[1].pin_oe[5]}, {7'h0, !i[2]});
      if (i[1]) check("select pin free", {7'h0, pad[1].pin_oe[7]}, 8'h01);
      check("select source", {7'h0, sel_in}, {7'h0, i[1] ? i[0] : pin[1][7]});
    end
    spi_active <= 1'b0;
    $display("test misc two done");
    for (int p = 0; p < 3; p++) wr(base_of(p) + 8'h01, 8'h00);
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        en[g] <= 8'h03;
        en[1 - g] <= 8'h00;
        de[g] <= 8'hFF;
        dv[g] <= 8'hFF;
        repeat (3) @(posedge aclk);
        wr(gpm_pkg::IDX_MISC_ONE, g != 0 ? {c[1:0], 6'h00} : {3'h0, c[1:0], 3'h0});
        pulse(g);
        check("irq idle", irq_of(g), 8'h00);
        dv[g][1] <= 1'b0;
        repeat (3) @(posedge aclk);
        check("irq fall", irq_of(g), 8'(c != 1));
        dv[g][0] <= 1'b0;
        @(posedge aclk);
        dv[g][0] <= 1'b1;
        pulse(g);
        repeat (2) @(posedge aclk);
        check("irq masked line", irq_of(g), 8'(c == 0));
        dv[g][1] <= 1'b1;
        repeat (3) @(posedge aclk);
        check("irq rise", irq_of(g), 8'(c != 2));
      end
    end
    $display("test interrupts done");
    results();
  end
endmodule
